// File: logic/aic_chan.sv
// One conditioning channel: bias by mode, then gain, then low-pass filter.
// Assumes samples arrive on mclk with a one-cycle valid strobe.
module aic_chan #(
  parameter int unsigned STEP_CYC = aic_pkg::FILTER_STEP_CYC
) (
  // Clock and reset
  input wire logic mclk,
  input wire logic rst,
  // Settings, sample and result
  aic_cond_if.chan cond
);

  localparam int FW = 16 + aic_pkg::FILTER_SHIFT;

  logic signed [17:0] x;
  logic signed [17:0] b;
  logic signed [17:0] abs_b;
  logic signed [17:0] sum;
  logic signed [17:0] biased;
  logic signed [33:0] prod;
  logic signed [33:0] scaled;
  logic signed [15:0] next_gained;
  logic signed [15:0] gained;
  logic signed [FW-1:0] target;
  logic signed [FW-1:0] delta;
  logic signed [FW-1:0] acc;
  logic [31:0] limit;
  logic [31:0] cnt;
  logic step;
  logic nudge;

  // Bias stage, widened so no sum can wrap
  assign x = 18'(cond.sample);
  assign b = 18'(cond.bias);
  assign abs_b = b[17] ? -b : b;
  assign sum = x + b;

  // Bias mode selects how the offset shapes the input
  always_comb begin
    unique case (cond.bias_mode)
      aic_pkg::BM_NONE: biased = x;
      aic_pkg::BM_AT_OR_BELOW: biased = (sum > b) ? b : sum;
      aic_pkg::BM_AT_OR_ABOVE: biased = (sum < b) ? b : sum;
      aic_pkg::BM_ABS_CENTRE: biased = x - abs_b;
      aic_pkg::BM_BIAS_CENTRE: biased = x - b;
      default: biased = x;
    endcase
  end

  // Gain after bias, saturated so large gains clip instead of wrapping
  assign prod = biased * cond.gain;
  assign scaled = prod / aic_pkg::PCT_ONE;
  assign next_gained = (scaled > 34'(aic_pkg::SAT_MAX)) ? aic_pkg::SAT_MAX :
    (scaled < 34'(aic_pkg::SAT_MIN)) ? aic_pkg::SAT_MIN : scaled[15:0];

  always_ff @(posedge mclk) begin
    if (rst) begin
      gained <= '0;
    end else if (cond.sample_valid) begin
      gained <= next_gained;
    end
  end

  // Filter step timing scales with the programmed time constant
  assign limit = 32'(cond.filter_time) * 32'(STEP_CYC);
  assign step = (cnt + 32'h1) >= limit;
  assign target = FW'(gained) <<< aic_pkg::FILTER_SHIFT;
  assign delta = (target - acc) >>> aic_pkg::FILTER_SHIFT;
  // Floor shift stalls a rising output one step short; creep the last bit in
  assign nudge = (delta == '0) && (target > acc);

  always_ff @(posedge mclk) begin
    if (rst || step) begin
      cnt <= '0;
    end else begin
      cnt <= cnt + 32'h1;
    end
  end

  // First-order filter; a zero time constant passes the input straight on
  always_ff @(posedge mclk) begin
    if (rst) begin
      acc <= '0;
    end else if (cond.filter_time == '0) begin
      acc <= target;
    end else if (step) begin
      acc <= acc + delta + FW'(nudge);
    end
  end

  assign cond.result = acc[FW-1:aic_pkg::FILTER_SHIFT];

endmodule : aic_chan

// File: logic/aic_cond_if.sv
// Carrier between the parameter core and one conditioning channel.
// Assumes the core drives settings and samples, the channel drives result.
interface aic_cond_if;
  logic signed [15:0] sample;
  logic sample_valid;
  logic signed [15:0] bias;
  aic_pkg::aic_bias_mode_t bias_mode;
  logic signed [15:0] gain;
  logic [15:0] filter_time;
  logic signed [15:0] result;

  modport ctrl (output sample, sample_valid, bias, bias_mode, gain, filter_time,
    input result);
  modport chan (input sample, sample_valid, bias, bias_mode, gain, filter_time,
    output result);
endinterface : aic_cond_if

// File: logic/aic_loss_det.sv
// Current loop loss detector for the 4-20 mA input.
// Assumes the loop current arrives on mclk in 0.01 mA units.
module aic_loss_det #(
  parameter int unsigned HOLD_CYC = aic_pkg::LOSS_HOLD_CYC
) (
  // Clock and reset
  input wire logic mclk,
  input wire logic rst,
  // Measurement
  input wire logic current_mode,
  input wire logic [15:0] loop_current,
  // Result
  output logic lost
);

  logic [31:0] low_cnt;
  logic below;
  logic held;

  // A short dip is not a loss; the level must stay low for the hold time
  assign below = current_mode && (loop_current < aic_pkg::LOSS_THRESH);
  assign held = low_cnt >= 32'(HOLD_CYC - 1);

  always_ff @(posedge mclk) begin
    if (rst || !below) begin
      low_cnt <= '0;
    end else if (!held) begin
      low_cnt <= low_cnt + 32'h1;
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      lost <= 1'b0;
    end else begin
      lost <= below && held;
    end
  end

endmodule : aic_loss_det

// File: logic/aic_pkg.sv
// Shared constants for the analog input conditioning block: register map,
// reset values, setting limits, selector encodings and timing counts.
// Assumes a 40 MHz mclk and 16-bit parameter words.
package aic_pkg;

  // Geometry
  localparam int NUM_AIN = 2;
  localparam int NUM_FUNC = 14;
  localparam int FILTER_SHIFT = 8;

  // Parameter addresses, one word each, index 0 is input one
  localparam logic [1:0][15:0] ADDR_FSEL = {16'h0301, 16'h0300};
  localparam logic [1:0][15:0] ADDR_BIAS = {16'h0303, 16'h0302};
  localparam logic [1:0][15:0] ADDR_BMODE = {16'h0308, 16'h0304};
  localparam logic [15:0] ADDR_NFR = 16'h030a;
  localparam logic [1:0][15:0] ADDR_GAIN = {16'h030c, 16'h030b};
  localparam logic [1:0][15:0] ADDR_FTIME = {16'h0310, 16'h030f};
  localparam logic [15:0] ADDR_ADD = 16'h0312;
  localparam logic [15:0] ADDR_LOSS = 16'h0313;

  // Reset and parameter-reset values
  localparam logic [1:0][15:0] FSEL_RST = {16'h0000, 16'h0001};
  localparam logic [15:0] BIAS_RST = 16'h0000;
  localparam logic [15:0] BMODE_RST = 16'h0000;
  localparam logic [15:0] GAIN_RST = 16'h03e8;
  localparam logic [15:0] FTIME_RST = 16'h0001;
  localparam logic [15:0] NFR_RST = 16'h0000;
  localparam logic [15:0] ADD_RST = 16'h0000;
  localparam logic [15:0] LOSS_RST = 16'h0000;

  // Accepted ranges: bias and gain in 0.1 %, filter time in 0.01 s
  localparam logic [15:0] FSEL_MAX = 16'h000d;
  localparam logic signed [15:0] BIAS_MAX = 16'sh03e8;
  localparam logic [15:0] BMODE_MAX = 16'h0004;
  localparam logic signed [15:0] GAIN_MAX = 16'sh1388;
  localparam logic [15:0] FTIME_MAX = 16'h07d0;
  localparam logic [15:0] FLAG_MAX = 16'h0001;
  localparam logic [15:0] LOSS_MAX = 16'h0003;

  // Arithmetic: gain unit is 100.0 %, results saturate to 16 bits
  localparam logic signed [33:0] PCT_ONE = 34'sh003e8;
  localparam logic signed [15:0] SAT_MAX = 16'sh7fff;
  localparam logic signed [15:0] SAT_MIN = -16'sh7fff;

  // Filter: one 0.01 s unit of time constant spread over 2^FILTER_SHIFT steps
  localparam int CLK_HZ = 40_000_000;
  localparam int FILTER_UNIT_MS = 10;
  localparam int FILTER_STEP_CYC = (FILTER_UNIT_MS * (CLK_HZ / 1000)) >> FILTER_SHIFT;

  // Current loop loss: threshold in 0.01 mA, must persist for the hold time
  localparam logic [15:0] LOSS_THRESH = 16'h015e;
  localparam int LOSS_HOLD_MS = 100;
  localparam int LOSS_HOLD_CYC = LOSS_HOLD_MS * (CLK_HZ / 1000);

  // Fault code shown on a stopping loss; value is arbitrary
  localparam logic [7:0] LOSS_FAULT_CODE = 8'h5a;

  // Function served by an input
  typedef enum logic [3:0] {
    FN_NONE, FN_FREQ, FN_TORQUE, FN_TQ_COMP, FN_PID_TARGET, FN_PID_FB, FN_THERMISTOR,
    FN_POS_TQ_LIM, FN_NEG_TQ_LIM, FN_REGEN_TQ_LIM, FN_BOTH_TQ_LIM, FN_RTD, FN_AUX_FREQ,
    FN_PID_COMP
  } aic_func_t;

  // Bias application mode
  typedef enum logic [2:0] {
    BM_NONE, BM_AT_OR_BELOW, BM_AT_OR_ABOVE, BM_ABS_CENTRE, BM_BIAS_CENTRE
  } aic_bias_mode_t;

  // Action on current loop loss
  typedef enum logic [1:0] {LA_NONE, LA_HOLD, LA_DECEL, LA_STOP} aic_loss_act_t;

endpackage : aic_pkg

// File: logic/aic_top.sv
// Analog input conditioning: parameter words, two conditioning channels,
// function routing, direction handling and current loop loss reaction.
// Assumes a parameter host on mclk and converter samples already on mclk.
module aic_top #(
  parameter int unsigned LOSS_HOLD_CYC = aic_pkg::LOSS_HOLD_CYC,
  parameter int unsigned FILTER_STEP_CYC = aic_pkg::FILTER_STEP_CYC
) (
  // Clock and reset
  input wire logic mclk,
  input wire logic rst,
  // Parameter word port
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [15:0] reg_addr,
  input wire logic [15:0] reg_wdata,
  output logic [15:0] reg_rdata,
  output logic reg_ack,
  output logic reg_reject,
  // Drive state
  input wire logic motor_running,
  input wire logic parameter_reset_command,
  input wire logic keypad_reverse,
  // Converter samples, 0.1 percent units
  input wire logic signed [15:0] analog_input_one,
  input wire logic signed [15:0] analog_input_two,
  input wire logic sample_valid,
  input wire logic ain2_current_mode,
  input wire logic [15:0] ain2_loop_current,
  // Routed function values
  output logic [aic_pkg::NUM_FUNC-1:1][15:0] func_value,
  output logic [aic_pkg::NUM_FUNC-1:1] func_active,
  // Speed command and loss reaction
  output logic [15:0] freq_command,
  output logic run_reverse,
  output logic loss_detected,
  output logic loss_hold_freq,
  output logic loss_decel,
  output logic loss_stop,
  output logic [7:0] signal_loss_fault_code
);

  // Parameter words, index 0 is input one
  logic [15:0] fsel [aic_pkg::NUM_AIN];
  logic [15:0] bias [aic_pkg::NUM_AIN];
  logic [15:0] bmode [aic_pkg::NUM_AIN];
  logic [15:0] gain [aic_pkg::NUM_AIN];
  logic [15:0] ftime [aic_pkg::NUM_AIN];
  logic [15:0] nfr;
  logic [15:0] add_en;
  logic [15:0] loss_act;

  // Decode
  logic [aic_pkg::NUM_AIN-1:0] hit_fsel;
  logic [aic_pkg::NUM_AIN-1:0] hit_bias;
  logic [aic_pkg::NUM_AIN-1:0] hit_bmode;
  logic [aic_pkg::NUM_AIN-1:0] hit_gain;
  logic [aic_pkg::NUM_AIN-1:0] hit_ftime;
  logic hit_nfr;
  logic hit_add;
  logic hit_loss;
  logic mapped;
  logic signed [15:0] wsigned;
  logic fsel_ok;
  logic bias_ok;
  logic bmode_ok;
  logic gain_ok;
  logic ftime_ok;
  logic flag_ok;
  logic loss_ok;
  logic value_ok;
  logic run_block;
  logic wr_accept;
  logic [15:0] rd_part [aic_pkg::NUM_AIN];
  logic [15:0] rd_value;

  // Datapath
  logic signed [15:0] ain_sample [aic_pkg::NUM_AIN];
  logic signed [15:0] cond_out [aic_pkg::NUM_AIN];
  logic signed [16:0] wide_sum;
  logic signed [15:0] sum_sat;
  logic signed [15:0] src [aic_pkg::NUM_AIN];
  logic [15:0] route_val [aic_pkg::NUM_FUNC];
  logic route_act [aic_pkg::NUM_FUNC];
  logic lost;
  aic_pkg::aic_loss_act_t act;
  logic signed [15:0] freq_src;
  logic freq_neg;
  logic allow_rev;
  logic [15:0] next_freq;
  logic next_reverse;
  logic hold_now;
  logic decel_now;
  logic stop_now;
  logic next_stop;
  logic kp_rev_meta;
  logic kp_rev_sync;

  aic_cond_if cond [aic_pkg::NUM_AIN] ();

  // Address decode per input, each word sits at its printed address
  genvar gi;
  generate
    for (gi = 0; gi < aic_pkg::NUM_AIN; gi++) begin : g_dec
      assign hit_fsel[gi] = reg_addr == aic_pkg::ADDR_FSEL[gi];
      assign hit_bias[gi] = reg_addr == aic_pkg::ADDR_BIAS[gi];
      assign hit_bmode[gi] = reg_addr == aic_pkg::ADDR_BMODE[gi];
      assign hit_gain[gi] = reg_addr == aic_pkg::ADDR_GAIN[gi];
      assign hit_ftime[gi] = reg_addr == aic_pkg::ADDR_FTIME[gi];
      assign rd_part[gi] = ({16{hit_fsel[gi]}} & fsel[gi]) |
        ({16{hit_bias[gi]}} & bias[gi]) | ({16{hit_bmode[gi]}} & bmode[gi]) |
        ({16{hit_gain[gi]}} & gain[gi]) | ({16{hit_ftime[gi]}} & ftime[gi]);
    end
  endgenerate

  assign hit_nfr = reg_addr == aic_pkg::ADDR_NFR;
  assign hit_add = reg_addr == aic_pkg::ADDR_ADD;
  assign hit_loss = reg_addr == aic_pkg::ADDR_LOSS;
  assign mapped = |{hit_fsel, hit_bias, hit_bmode, hit_gain, hit_ftime, hit_nfr, hit_add,
    hit_loss};

  // Addresses are exclusive, so an OR of masked words is the read mux
  assign rd_value = rd_part[0] | rd_part[1] | ({16{hit_nfr}} & nfr) |
    ({16{hit_add}} & add_en) | ({16{hit_loss}} & loss_act);

  // Range checks; an out-of-range value is refused, not clipped
  // so the mode and action casts never meet an unlisted code
  assign wsigned = reg_wdata;
  assign fsel_ok = reg_wdata <= aic_pkg::FSEL_MAX;
  assign bias_ok = (wsigned >= -aic_pkg::BIAS_MAX) && (wsigned <= aic_pkg::BIAS_MAX);
  assign bmode_ok = reg_wdata <= aic_pkg::BMODE_MAX;
  assign gain_ok = (wsigned >= -aic_pkg::GAIN_MAX) && (wsigned <= aic_pkg::GAIN_MAX);
  assign ftime_ok = reg_wdata <= aic_pkg::FTIME_MAX;
  assign flag_ok = reg_wdata <= aic_pkg::FLAG_MAX;
  assign loss_ok = reg_wdata <= aic_pkg::LOSS_MAX;
  assign value_ok = (|hit_fsel && fsel_ok) || (|hit_bias && bias_ok) ||
    (|hit_bmode && bmode_ok) || (|hit_gain && gain_ok) || (|hit_ftime && ftime_ok) ||
    ((hit_nfr || hit_add) && flag_ok) || (hit_loss && loss_ok);

  // Only the loss action word is locked while the motor runs
  // A refused write leaves the word as it was and answers with reject
  assign run_block = hit_loss && motor_running;
  assign wr_accept = reg_wr && mapped && value_ok && !run_block;

  // Per-input parameter words; the parameter reset command wins over a write
  always_ff @(posedge mclk) begin
    for (int i = 0; i < aic_pkg::NUM_AIN; i++) begin
      if (rst || parameter_reset_command) begin
        fsel[i] <= aic_pkg::FSEL_RST[i];
        bias[i] <= aic_pkg::BIAS_RST;
        bmode[i] <= aic_pkg::BMODE_RST;
        gain[i] <= aic_pkg::GAIN_RST;
        ftime[i] <= aic_pkg::FTIME_RST;
      end else if (wr_accept) begin
        if (hit_fsel[i]) fsel[i] <= reg_wdata;
        if (hit_bias[i]) bias[i] <= reg_wdata;
        if (hit_bmode[i]) bmode[i] <= reg_wdata;
        if (hit_gain[i]) gain[i] <= reg_wdata;
        if (hit_ftime[i]) ftime[i] <= reg_wdata;
      end
    end
  end

  // Shared words
  always_ff @(posedge mclk) begin
    if (rst || parameter_reset_command) begin
      nfr <= aic_pkg::NFR_RST;
      add_en <= aic_pkg::ADD_RST;
      loss_act <= aic_pkg::LOSS_RST;
    end else if (wr_accept) begin
      if (hit_nfr) nfr <= reg_wdata;
      if (hit_add) add_en <= reg_wdata;
      if (hit_loss) loss_act <= reg_wdata;
    end
  end

  // Answer one cycle after each access; a write wins over a same-cycle read
  // Unmapped reads answer zero with reject, so a host can probe the map
  always_ff @(posedge mclk) begin
    if (rst) begin
      reg_ack <= 1'b0;
      reg_reject <= 1'b0;
      reg_rdata <= '0;
    end else begin
      reg_ack <= reg_wr || reg_rd;
      reg_reject <= reg_wr ? !wr_accept : (reg_rd && !mapped);
      reg_rdata <= (reg_rd && !reg_wr && mapped) ? rd_value : '0;
    end
  end

  // Conditioning channels
  assign ain_sample[0] = analog_input_one;
  assign ain_sample[1] = analog_input_two;

  generate
    for (gi = 0; gi < aic_pkg::NUM_AIN; gi++) begin : g_chan
      assign cond[gi].sample = ain_sample[gi];
      assign cond[gi].sample_valid = sample_valid;
      assign cond[gi].bias = bias[gi];
      assign cond[gi].bias_mode = aic_pkg::aic_bias_mode_t'(bmode[gi][2:0]);
      assign cond[gi].gain = gain[gi];
      assign cond[gi].filter_time = ftime[gi];
      assign cond_out[gi] = cond[gi].result;

      aic_chan #(
        .STEP_CYC(FILTER_STEP_CYC)
      ) u_chan (
        .mclk(mclk),
        .rst(rst),
        .cond(cond[gi])
      );
    end
  endgenerate

  // Summing; the total goes to input one's function and input two drops out
  // Saturation keeps two full-scale inputs from wrapping to the other sign
  assign wide_sum = 17'(cond_out[0]) + 17'(cond_out[1]);
  assign sum_sat = (wide_sum > 17'(aic_pkg::SAT_MAX)) ? aic_pkg::SAT_MAX :
    (wide_sum < 17'(aic_pkg::SAT_MIN)) ? aic_pkg::SAT_MIN : wide_sum[15:0];
  assign src[0] = add_en[0] ? sum_sat : cond_out[0];
  assign src[1] = cond_out[1];

  // Routing by selector; input one has priority if both pick one function
  // Unselected functions read zero with their active bit low
  assign route_val[0] = '0;
  assign route_act[0] = 1'b0;
  generate
    for (gi = 1; gi < aic_pkg::NUM_FUNC; gi++) begin : g_route
      logic pick1;
      logic pick2;
      assign pick1 = fsel[0] == 16'(gi);
      assign pick2 = (fsel[1] == 16'(gi)) && !add_en[0];
      assign route_val[gi] = pick1 ? src[0] : (pick2 ? src[1] : '0);
      assign route_act[gi] = pick1 || pick2;

      always_ff @(posedge mclk) begin
        if (rst) begin
          func_value[gi] <= '0;
          func_active[gi] <= 1'b0;
        end else begin
          func_value[gi] <= route_val[gi];
          func_active[gi] <= route_act[gi];
        end
      end
    end
  endgenerate

  // Current loop loss detection on input two
  aic_loss_det #(
    .HOLD_CYC(LOSS_HOLD_CYC)
  ) u_loss (
    .mclk(mclk),
    .rst(rst),
    .current_mode(ain2_current_mode),
    .loop_current(ain2_loop_current),
    .lost(lost)
  );

  // Loss reaction decode
  assign act = aic_pkg::aic_loss_act_t'(loss_act[1:0]);
  assign hold_now = lost && (act == aic_pkg::LA_HOLD);
  assign decel_now = lost && (act == aic_pkg::LA_DECEL);
  assign stop_now = lost && (act == aic_pkg::LA_STOP);

  // Stop latches until the loop is back and the motor has come to rest
  assign next_stop = stop_now || (loss_stop && (lost || motor_running));

  // Keypad and terminal direction arrives from pins; two flops before use
  always_ff @(posedge mclk) begin
    if (rst) begin
      kp_rev_meta <= 1'b0;
      kp_rev_sync <= 1'b0;
    end else begin
      kp_rev_meta <= keypad_reverse;
      kp_rev_sync <= kp_rev_meta;
    end
  end

  // Frequency command: sign handling and direction source
  assign freq_src = route_val[aic_pkg::FN_FREQ];
  assign freq_neg = freq_src[15];
  assign allow_rev = nfr[0];
  assign next_freq = !route_act[aic_pkg::FN_FREQ] ? '0 :
    !freq_neg ? freq_src : (allow_rev ? 16'(-freq_src) : '0);
  assign next_reverse = allow_rev ? (route_act[aic_pkg::FN_FREQ] && freq_neg) :
    kp_rev_sync;

  // Command outputs; hold freezes the last value, decel and stop force zero
  // Hold keeps direction too, so a lost loop never flips the motor
  always_ff @(posedge mclk) begin
    if (rst) begin
      freq_command <= '0;
      run_reverse <= 1'b0;
    end else if (hold_now) begin
      freq_command <= freq_command;
      run_reverse <= run_reverse;
    end else if (decel_now || next_stop) begin
      freq_command <= '0;
      run_reverse <= run_reverse;
    end else begin
      freq_command <= next_freq;
      run_reverse <= next_reverse;
    end
  end

  // Loss status flags; action 0 raises only the detection flag
  // Flags follow the detector each cycle; only the stop flag latches
  always_ff @(posedge mclk) begin
    if (rst) begin
      loss_detected <= 1'b0;
      loss_hold_freq <= 1'b0;
      loss_decel <= 1'b0;
      loss_stop <= 1'b0;
      signal_loss_fault_code <= '0;
    end else begin
      loss_detected <= lost;
      loss_hold_freq <= hold_now;
      loss_decel <= decel_now;
      loss_stop <= next_stop;
      signal_loss_fault_code <= next_stop ? aic_pkg::LOSS_FAULT_CODE : '0;
    end
  end

endmodule : aic_top

// File: tb/aic_src_model.sv
// Analog source stand-in: converter samples with a strobe every 4 cycles.
// Assumes the bench sets the levels; each level is registered once on its way out.
module aic_src_model (
  // Clock and reset
  input wire logic mclk,
  input wire logic rst,
  // Levels from the bench
  input wire logic signed [15:0] lvl_one,
  input wire logic signed [15:0] lvl_two,
  // Converter side
  output logic signed [15:0] ain_one,
  output logic signed [15:0] ain_two,
  output logic svalid
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [1:0] cnt;
  // Sparse strobe, so a level change needs up to 4 cycles to be seen
  always_ff @(posedge mclk) begin
    cnt <= rst ? 2'h0 : cnt + 2'h1;
    svalid <= !rst && cnt == 2'h3;
    ain_one <= lvl_one;
    ain_two <= lvl_two;
  end
endmodule : aic_src_model

// File: tb/aic_top_properties.sv
// Port checks on the parameter port, loss reaction and fault code.
// Assumes it is bound into aic_top and shares its clock and reset.
module aic_top_chk (
  // Clock and reset
  input wire logic mclk,
  input wire logic rst,
  // Parameter port
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [15:0] reg_addr,
  input wire logic [15:0] reg_wdata,
  input wire logic [15:0] reg_rdata,
  input wire logic reg_ack,
  input wire logic reg_reject,
  // Drive state and reaction
  input wire logic motor_running,
  input wire logic parameter_reset_command,
  input wire logic [15:0] freq_command,
  input wire logic loss_hold_freq,
  input wire logic loss_stop,
  input wire logic [7:0] signal_loss_fault_code
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge mclk); endclocking
  default disable iff (rst);
  // Reads and writes; a parameter reset overrides the same-cycle write
  a_ack_follows: assert property ((reg_wr || reg_rd) |=> reg_ack) else $error("ack missing");
  a_ack_uncaused: assert property (!(reg_wr || reg_rd) |=> !reg_ack) else $error("stray ack");
  a_reject_in_ack: assert property (reg_reject |-> reg_ack) else $error("reject without ack");
  a_rdata_quiet: assert property (!reg_ack |-> reg_rdata == 16'h0) else $error("rdata not idle");
  a_loss_run_lock: assert property (reg_wr && reg_addr == 16'h0313 && motor_running
    && !parameter_reset_command |=> reg_reject) else $error("loss word taken in run");
  a_fsel_range: assert property (reg_wr && reg_addr == 16'h0300 && reg_wdata > 16'h000d
    && !parameter_reset_command |=> reg_reject) else $error("selector out of range taken");
  a_fault_code: assert property (signal_loss_fault_code ==
    (loss_stop ? aic_pkg::LOSS_FAULT_CODE : 8'h00)) else $error("fault code wrong");
  a_stop_freq_zero: assert property (loss_stop && $past(loss_stop)
    |-> freq_command == 16'h0) else $error("freq not zero on stop");
  a_hold_frozen: assert property (loss_hold_freq && $past(loss_hold_freq)
    |-> $stable(freq_command)) else $error("freq moved on hold");
  c_stop: cover property (loss_stop);
  c_hold: cover property (loss_hold_freq);
  c_refused: cover property (reg_ack && reg_reject);
endmodule : aic_top_chk

bind aic_top aic_top_chk aic_top_chk_inst (.mclk(mclk), .rst(rst), .reg_wr(reg_wr),
  .reg_rd(reg_rd), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
  .reg_ack(reg_ack), .reg_reject(reg_reject), .motor_running(motor_running),
  .parameter_reset_command(parameter_reset_command), .freq_command(freq_command),
  .loss_hold_freq(loss_hold_freq), .loss_stop(loss_stop),
  .signal_loss_fault_code(signal_loss_fault_code));

// File: tb/aic_top_tb.sv
// Self-checking bench for aic_top through its parameter word port.
// Assumes short hold and filter counts so the run stays brief.
module aic_top_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic mclk = 1'b0, rst = 1'b1, reg_wr = 1'b0, reg_rd = 1'b0, run = 1'b0, prc = 1'b0;
  logic kp_rev = 1'b0, cur_mode = 1'b0, svalid, ack, rej, rej_q, rev, det, hold, decel, stop;
  logic [15:0] reg_addr = 16'h0, reg_wdata = 16'h0, loop_cur = 16'h03e8, rdata, rdata_q, freq;
  logic signed [15:0] lvl_one = 16'sh0, lvl_two = 16'sh0, ain_one, ain_two;
  logic [13:1][15:0] fval;
  logic [13:1] fact;
  logic [7:0] fcode;
  int failures = 0, n_checks = 0;
  logic [15:0] ra [13] = '{16'h0300, 16'h0301, 16'h0302, 16'h0303, 16'h0304, 16'h0308,
    16'h030a, 16'h030b, 16'h030c, 16'h030f, 16'h0310, 16'h0312, 16'h0313};
  logic [15:0] rv [13] = '{16'h1, 16'h0, 16'h0, 16'h0, 16'h0, 16'h0, 16'h0, 16'h03e8,
    16'h03e8, 16'h1, 16'h1, 16'h0, 16'h0};
  // Field edges: address, last legal value at the upper or lower end, first refused value past it
  logic [15:0] ba [10] = '{16'h0300, 16'h0302, 16'h0302, 16'h030b, 16'h030b, 16'h030f,
    16'h0304, 16'h030a, 16'h0312, 16'h0313};
  logic [15:0] bok [10] = '{16'h000d, 16'h03e8, 16'hfc18, 16'h1388, 16'hec78, 16'h07d0,
    16'h4, 16'h1, 16'h1, 16'h3};
  logic [15:0] bbad [10] = '{16'h000e, 16'h03e9, 16'hfc17, 16'h1389, 16'hec77, 16'h07d1,
    16'h5, 16'h2, 16'h2, 16'h4};
  // Input 500, bias -100, modes 0 to 4; a negative bias splits modes 3 and 4
  logic [15:0] me [5] = '{16'd500, 16'hff9c, 16'd400, 16'd400, 16'd600};

  always #12.5 mclk = ~mclk;

  aic_src_model aic_src_model_inst (.mclk(mclk), .rst(rst), .lvl_one(lvl_one),
    .lvl_two(lvl_two), .ain_one(ain_one), .ain_two(ain_two), .svalid(svalid));
  aic_top #(.LOSS_HOLD_CYC(16), .FILTER_STEP_CYC(2)) aic_top_inst (.mclk(mclk), .rst(rst),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_rdata(rdata), .reg_ack(ack), .reg_reject(rej), .motor_running(run),
    .parameter_reset_command(prc), .keypad_reverse(kp_rev), .analog_input_one(ain_one),
    .analog_input_two(ain_two), .sample_valid(svalid), .ain2_current_mode(cur_mode),
    .ain2_loop_current(loop_cur), .func_value(fval), .func_active(fact),
    .freq_command(freq), .run_reverse(rev), .loss_detected(det), .loss_hold_freq(hold),
    .loss_decel(decel), .loss_stop(stop), .signal_loss_fault_code(fcode));

  task automatic chk(input string nm, input logic [15:0] e, g);
    n_checks++;
    if (g !== e) begin
      failures++;
      $display("ERROR %s expected %h seen %h", nm, e, g);
    end
  endtask : chk

  // One access; the answer lands one cycle after the request edge
  task automatic acc(input logic w, input logic [15:0] a, d);
    @(posedge mclk);
    reg_wr <= w;
    reg_rd <= !w;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge mclk);
    reg_wr <= 1'b0;
    reg_rd <= 1'b0;
    #1;
    chk("ack", 16'h1, {15'h0, ack});
    rej_q = rej;
    rdata_q = rdata;
  endtask : acc

  task automatic wr(input logic [15:0] a, d, input logic r);
    acc(1'b1, a, d);
    chk("reject", {15'h0, r}, {15'h0, rej_q});
  endtask : wr

  task automatic rd(input logic [15:0] a, e);
    acc(1'b0, a, 16'h0);
    chk("rdata", e, rdata_q);
  endtask : rd

  task automatic smp(input logic [15:0] a, b);
    @(posedge mclk);
    lvl_one <= a;
    lvl_two <= b;
    repeat (12) @(posedge mclk);
    #1;
  endtask : smp

  task automatic end_sim;
    if (failures == 0 && n_checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : end_sim

  // Watchdog well beyond the few thousand cycles the tests need
  initial begin
    repeat (30000) @(posedge mclk);
    failures++;
    end_sim();
  end

  initial begin
    repeat (20) @(posedge mclk);
    rst <= 1'b0;
    foreach (ra[i]) rd(ra[i], rv[i]);
    foreach (ba[i]) begin
      wr(ba[i], bbad[i], 1'b1);
      wr(ba[i], bok[i], 1'b0);
      rd(ba[i], bok[i]);
    end
    rd(16'h0305, 16'h0);
    chk("reject", 16'h1, {15'h0, rej_q});
    @(posedge mclk) run <= 1'b1;
    wr(16'h0313, 16'h2, 1'b1);
    wr(16'h0312, 16'h0, 1'b0);
    @(posedge mclk) run <= 1'b0;
    @(posedge mclk) prc <= 1'b1;
    @(posedge mclk) prc <= 1'b0;
    foreach (ra[i]) rd(ra[i], rv[i]);
    wr(16'h030f, 16'h0, 1'b0);
    wr(16'h0310, 16'h0, 1'b0);
    wr(16'h0302, 16'hff9c, 1'b0);
    for (int m = 0; m < 5; m++) begin
      wr(16'h0304, 16'(m), 1'b0);
      smp(16'd500, 16'h0);
      chk("func_one", me[m], fval[1]);
    end
    wr(16'h0302, 16'h0, 1'b0);
    wr(16'h0304, 16'h0, 1'b0);
    wr(16'h030f, 16'h1, 1'b0);
    smp(16'd900, 16'h0);
    chk("filter", 16'h1, {15'h0, fval[1] < 16'd700});
    #125000;
    chk("filter", 16'd900, fval[1]);
    wr(16'h030f, 16'h0, 1'b0);
    wr(16'h030b, 16'h07d0, 1'b0);
    smp(16'd250, 16'h0);
    chk("freq", 16'd500, freq);
    wr(16'h030b, 16'h03e8, 1'b0);
    @(posedge mclk) kp_rev <= 1'b1;
    smp(-16'sd500, 16'h0);
    chk("freq", 16'h0, freq);
    chk("reverse", 16'h1, {15'h0, rev});
    wr(16'h030a, 16'h1, 1'b0);
    @(posedge mclk) kp_rev <= 1'b0;
    smp(-16'sd500, 16'h0);
    chk("freq", 16'd500, freq);
    chk("reverse", 16'h1, {15'h0, rev});
    wr(16'h0312, 16'h1, 1'b0);
    smp(16'd300, 16'd200);
    chk("sum", 16'd500, fval[1]);
    wr(16'h0312, 16'h0, 1'b0);
    for (int k = 2; k < 14; k++) begin
      wr(16'h0301, 16'(k), 1'b0);
      smp(16'h0, 16'd250);
      chk("func_two", 16'd250, fval[k]);
      chk("active", 16'h1, {15'h0, fact[k]});
    end
    @(posedge mclk) cur_mode <= 1'b1;
    for (int a = 0; a < 4; a++) begin
      @(posedge mclk) run <= 1'b0;
      loop_cur <= 16'h03e8;
      lvl_one <= 16'sd300;
      repeat (4) @(posedge mclk);
      wr(16'h0313, 16'(a), 1'b0);
      @(posedge mclk) run <= 1'b1;
      loop_cur <= 16'h0064;
      repeat (24) @(posedge mclk);
      #1;
      chk("loss", {12'h0, 1'b1, a == 3, a == 2, a == 1}, {12'h0, det, stop, decel, hold});
      chk("fault", (a == 3) ? 16'h005a : 16'h0, {8'h0, fcode});
      smp(16'd200, 16'h0);
      chk("freq", (a == 0) ? 16'd200 : ((a == 1) ? 16'd300 : 16'h0), freq);
    end
    end_sim();
  end
endmodule : aic_top_tb
